// ===== core/crp_codec.sv
// Completion packet builder and receive parser top
//
// Behaviour
// - One completion packet is emitted for each finished remote request.
// - Completions go to one destination over the same transmit port as requests.
// - Every completion carries format type 0b1101.
// - Transaction subfield is 0b0000 without payload and 0b1000 with payload.
// - The request tag of the original request is echoed in the completion.
// - A completion holds only status, optional payload and the echoed tag.
// - Status 0b0000 means done and 0b0001 means data only.
// - Status 0b0010 means the responder does not own the granule.
// - Status 0b0011 means not accepted and the requester must reissue.
// - Status 0b0100 carries intervention data for home memory to store.
// - Status 0b0101 means done after a third-party intervention.
// - Error status 0b0111 and no-data completions never carry a payload.
// - Status 0b1100 to 0b1111 are implementation codes; 0b0110, 0b1000-0b1011 reserved.
// - Format types 12 and 14 are never generated.
// - Format type 15 carries device-defined content such as flow control.
module crp_codec
   import crp_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Completion request from the local service logic
   input  wire logic              cmp_valid,
   output logic                   cmp_ready,
   input  wire logic [3:0]        cmp_status,
   input  wire logic [crp_pkg::TAG_W-1:0]  cmp_tag,
   input  wire logic              cmp_has_data,
   input  wire logic [crp_pkg::DATA_W-1:0] cmp_data,
   // Flow-control packet request
   input  wire logic              fc_valid,
   input  wire logic [3:0]        fc_code,
   // Shared transmit port
   output logic                   tx_valid,
   input  wire logic              tx_ready,
   output logic [3:0]             tx_ftype,
   output logic [3:0]             tx_trans,
   output logic [3:0]             tx_status,
   output logic [TAG_W-1:0]       tx_request_tag_echo,
   output logic                   tx_has_data,
   output logic [DATA_W-1:0]      tx_data,
   output logic                   tx_bad_status,
   // Receive port
   input  wire logic              rx_valid,
   input  wire logic [3:0]        rx_ftype,
   input  wire logic [3:0]        rx_trans,
   input  wire logic [3:0]        rx_status,
   input  wire logic [TAG_W-1:0]  rx_request_tag_echo,
   input  wire logic [DATA_W-1:0] rx_data,
   output logic                   done_valid,
   output logic [3:0]             done_status,
   output logic [TAG_W-1:0]       done_request_tag_echo,
   output logic                   done_has_data,
   output logic [DATA_W-1:0]      done_data,
   output logic                   done_retry,
   output logic                   done_interv,
   output logic                   rx_malformed,
   output logic                   rx_impl_valid
);
   import crp_pkg::*;

   typedef enum logic [1:0] {
      CRP_IDLE = 2'b01,
      CRP_SEND = 2'b10
   } crp_state_e;

   crp_state_e        state;
   crp_state_e        next_state;
   logic              next_tx_valid;
   logic [3:0]        next_tx_ftype;
   logic [3:0]        next_tx_trans;
   logic [3:0]        next_tx_status;
   logic [TAG_W-1:0]  next_tx_tag;
   logic              next_tx_has_data;
   logic [DATA_W-1:0] next_tx_data;
   logic              next_tx_bad_status;
   logic              next_cmp_ready;
   logic              send_data;

   // Completions take priority; flow control waits for an idle cycle
   always_comb begin
      next_state         = state;
      next_tx_valid      = tx_valid;
      next_tx_ftype      = tx_ftype;
      next_tx_trans      = tx_trans;
      next_tx_status     = tx_status;
      next_tx_tag        = tx_request_tag_echo;
      next_tx_has_data   = tx_has_data;
      next_tx_data       = tx_data;
      next_tx_bad_status = tx_bad_status;
      next_cmp_ready     = 1'b0;
      // Payload only where the status allows it
      send_data = cmp_has_data && status_may_carry_data(cmp_status);
      case (state)
         CRP_IDLE: begin
            next_cmp_ready = 1'b1;
            if (cmp_valid && cmp_ready) begin
               next_state         = CRP_SEND;
               next_cmp_ready     = 1'b0;
               next_tx_valid      = 1'b1;
               next_tx_ftype      = FTYPE_RESPONSE;
               next_tx_trans      = send_data ? TRANS_WITH_DATA : TRANS_NO_DATA;
               next_tx_status     = cmp_status;
               next_tx_tag        = cmp_tag;
               next_tx_has_data   = send_data;
               next_tx_data       = send_data ? cmp_data : '0;
               // Reserved status still goes out; flagged for the local logic
               next_tx_bad_status = status_reserved(cmp_status);
            end else if (fc_valid) begin
               next_state         = CRP_SEND;
               next_cmp_ready     = 1'b0;
               next_tx_valid      = 1'b1;
               next_tx_ftype      = FTYPE_IMPL;
               next_tx_trans      = fc_code;
               next_tx_status     = RST_NIBBLE;
               next_tx_tag        = '0;
               next_tx_has_data   = 1'b0;
               next_tx_data       = '0;
               next_tx_bad_status = 1'b0;
            end
         end
         CRP_SEND: begin
            if (tx_ready) begin
               next_state     = CRP_IDLE;
               next_tx_valid  = 1'b0;
               next_cmp_ready = 1'b1;
            end
         end
         default: begin
            next_state    = CRP_IDLE;
            next_tx_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state               <= CRP_IDLE;
         cmp_ready           <= 1'b0;
         tx_valid            <= 1'b0;
         tx_ftype            <= RST_NIBBLE;
         tx_trans            <= RST_NIBBLE;
         tx_status           <= RST_NIBBLE;
         tx_request_tag_echo <= '0;
         tx_has_data         <= 1'b0;
         tx_data             <= '0;
         tx_bad_status       <= 1'b0;
      end else begin
         state               <= next_state;
         cmp_ready           <= next_cmp_ready;
         tx_valid            <= next_tx_valid;
         tx_ftype            <= next_tx_ftype;
         tx_trans            <= next_tx_trans;
         tx_status           <= next_tx_status;
         tx_request_tag_echo <= next_tx_tag;
         tx_has_data         <= next_tx_has_data;
         tx_data             <= next_tx_data;
         tx_bad_status       <= next_tx_bad_status;
      end
   end

   crp_parse u_parse (
      .clk_sys       (clk_sys),
      .sys_rst       (sys_rst),
      .rx_valid      (rx_valid),
      .rx_ftype      (rx_ftype),
      .rx_trans      (rx_trans),
      .rx_status     (rx_status),
      .rx_tag        (rx_request_tag_echo),
      .rx_data       (rx_data),
      .done_valid    (done_valid),
      .done_status   (done_status),
      .done_tag      (done_request_tag_echo),
      .done_has_data (done_has_data),
      .done_data     (done_data),
      .done_retry    (done_retry),
      .done_interv   (done_interv),
      .malformed     (rx_malformed),
      .impl_valid    (rx_impl_valid)
   );

   AST_ONE_PER_ACCEPT: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cmp_valid && cmp_ready) |=> (tx_valid && tx_ftype == FTYPE_RESPONSE))
      else $error("accepted completion not emitted");
   AST_HOLD_UNTIL_TAKEN: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_request_tag_echo)
      && $stable(tx_ftype))) else $error("transmit dropped before taken");
   AST_FTYPE_LEGAL: assert property (@(posedge clk_sys) disable iff (sys_rst)
      tx_valid |-> (tx_ftype == FTYPE_RESPONSE || tx_ftype == FTYPE_IMPL))
      else $error("illegal format type sent");
   AST_RESERVED_FTYPE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      tx_valid |-> (tx_ftype != FTYPE_RSVD_12 && tx_ftype != FTYPE_RSVD_14))
      else $error("reserved format type sent");
   AST_TRANS_CODE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (tx_valid && tx_ftype == FTYPE_RESPONSE) |->
      (tx_trans == (tx_has_data ? TRANS_WITH_DATA : TRANS_NO_DATA)))
      else $error("transaction subfield wrong");
   AST_TAG_ECHO: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cmp_valid && cmp_ready) |=> (tx_request_tag_echo == $past(cmp_tag)
      && tx_status == $past(cmp_status))) else $error("tag or status not echoed");
   AST_ERROR_NO_DATA: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (tx_valid && (tx_status == ST_ERROR || tx_status == ST_NOT_OWNER
      || tx_status == ST_RETRY) && tx_ftype == FTYPE_RESPONSE) |-> !tx_has_data)
      else $error("payload on no-data status");
   AST_NO_ACCEPT_WHILE_BUSY: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (tx_valid && !tx_ready) |=> !cmp_ready) else $error("accepted while busy");
endmodule

// ===== core/crp_parse.sv
// Receive-side parser for completion packets
module crp_parse
   import crp_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              rx_valid,
   input  wire logic [3:0]        rx_ftype,
   input  wire logic [3:0]        rx_trans,
   input  wire logic [3:0]        rx_status,
   input  wire logic [TAG_W-1:0]  rx_tag,
   input  wire logic [DATA_W-1:0] rx_data,
   output logic                   done_valid,
   output logic [3:0]             done_status,
   output logic [TAG_W-1:0]       done_tag,
   output logic                   done_has_data,
   output logic [DATA_W-1:0]      done_data,
   output logic                   done_retry,
   output logic                   done_interv,
   output logic                   malformed,
   output logic                   impl_valid
);
   logic              next_done_valid;
   logic [3:0]        next_done_status;
   logic [TAG_W-1:0]  next_done_tag;
   logic              next_done_has_data;
   logic [DATA_W-1:0] next_done_data;
   logic              next_done_retry;
   logic              next_done_interv;
   logic              next_malformed;
   logic              next_impl_valid;
   logic              is_resp;
   logic              bad;

   always_comb begin
      is_resp = rx_valid && (rx_ftype == FTYPE_RESPONSE);
      // Reserved subfield or status, or data on a no-data status
      bad = (rx_trans != TRANS_NO_DATA && rx_trans != TRANS_WITH_DATA)
         || status_reserved(rx_status)
         || (rx_trans == TRANS_WITH_DATA && !status_may_carry_data(rx_status));
      next_malformed     = is_resp && bad;
      next_done_valid    = is_resp && !bad;
      next_done_status   = is_resp ? rx_status : RST_NIBBLE;
      next_done_tag      = is_resp ? rx_tag : '0;
      next_done_has_data = is_resp && !bad && (rx_trans == TRANS_WITH_DATA);
      next_done_data     = (is_resp && !bad && rx_trans == TRANS_WITH_DATA) ? rx_data : '0;
      next_done_retry    = is_resp && !bad && (rx_status == ST_RETRY);
      next_done_interv   = is_resp && !bad && (rx_status == ST_INTERV);
      next_impl_valid    = rx_valid && (rx_ftype == FTYPE_IMPL);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         done_valid    <= 1'b0;
         done_status   <= RST_NIBBLE;
         done_tag      <= '0;
         done_has_data <= 1'b0;
         done_data     <= '0;
         done_retry    <= 1'b0;
         done_interv   <= 1'b0;
         malformed     <= 1'b0;
         impl_valid    <= 1'b0;
      end else begin
         done_valid    <= next_done_valid;
         done_status   <= next_done_status;
         done_tag      <= next_done_tag;
         done_has_data <= next_done_has_data;
         done_data     <= next_done_data;
         done_retry    <= next_done_retry;
         done_interv   <= next_done_interv;
         malformed     <= next_malformed;
         impl_valid    <= next_impl_valid;
      end
   end

   AST_MALFORMED_DROPPED: assert property (@(posedge clk_sys) disable iff (sys_rst)
      malformed |-> !done_valid) else $error("malformed packet was delivered");
endmodule

// ===== core/crp_pkg.sv
// Package for the coherent response packet codec
package crp_pkg;
   localparam int TAG_W  = 8;
   localparam int DATA_W = 64;

   localparam logic [3:0] FTYPE_RESPONSE = 4'hd;
   localparam logic [3:0] FTYPE_RSVD_12  = 4'hc;
   localparam logic [3:0] FTYPE_RSVD_14  = 4'he;
   localparam logic [3:0] FTYPE_IMPL     = 4'hf;

   localparam logic [3:0] TRANS_NO_DATA   = 4'h0;
   localparam logic [3:0] TRANS_WITH_DATA = 4'h8;

   localparam logic [3:0] ST_DONE       = 4'h0;
   localparam logic [3:0] ST_DATA_ONLY  = 4'h1;
   localparam logic [3:0] ST_NOT_OWNER  = 4'h2;
   localparam logic [3:0] ST_RETRY      = 4'h3;
   localparam logic [3:0] ST_INTERV     = 4'h4;
   localparam logic [3:0] ST_DONE_INTV  = 4'h5;
   localparam logic [3:0] ST_RSVD_6     = 4'h6;
   localparam logic [3:0] ST_ERROR      = 4'h7;
   localparam logic [3:0] ST_IMPL_FIRST = 4'hc;

   localparam logic [3:0] RST_NIBBLE = 4'h0;

   function automatic logic status_reserved(input logic [3:0] st);
      status_reserved = (st == ST_RSVD_6) || (st[3:2] == 2'b10);
   endfunction

   function automatic logic status_may_carry_data(input logic [3:0] st);
      status_may_carry_data = (st == ST_DONE) || (st == ST_DATA_ONLY) || (st == ST_INTERV)
         || (st == ST_DONE_INTV) || (st >= ST_IMPL_FIRST);
   endfunction
endpackage

// ===== tb/crp_sink.sv
// Remote requester model on the transmit port
module crp_sink (
   input  wire logic                      clk_sys,
   input  wire logic                      slow,
   input  wire logic                      tx_valid,
   output logic                           tx_ready,
   input  wire logic [3:0]                tx_ftype,
   input  wire logic [3:0]                tx_trans,
   input  wire logic [3:0]                tx_status,
   input  wire logic [crp_pkg::TAG_W-1:0] tx_tag,
   input  wire logic                      tx_has_data,
   input  wire logic [63:0]               tx_data,
   input  wire logic                      tx_bad
);
   timeunit 1ns;
   timeprecision 1ns;
   import crp_pkg::*;
   int         pkt_count = 0;
   logic       saw_rsvd_ftype = 1'b0;
   logic [3:0] got_ftype, got_trans, got_status;
   logic [7:0] got_tag;
   logic       got_has, got_bad;
   logic [63:0] got_data;
   initial tx_ready = 1'b0;
   // Slow mode stalls every other cycle to stretch the hold
   always @(negedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'b1;
   // Single sink takes every completion whole
   always @(posedge clk_sys) begin
      if (tx_valid && tx_ready) begin
         pkt_count <= pkt_count + 1;
         got_ftype <= tx_ftype;
         got_trans <= tx_trans;
         got_status <= tx_status;
         got_tag <= tx_tag;
         got_has <= tx_has_data;
         got_data <= tx_data;
         got_bad <= tx_bad;
         if (tx_ftype == FTYPE_RSVD_12 || tx_ftype == FTYPE_RSVD_14) saw_rsvd_ftype <= 1'b1;
      end
   end
endmodule

// ===== tb/test_crp_codec.sv
// Self-checking bench for the completion codec
module test_crp_codec;
   timeunit 1ns;
   timeprecision 1ns;
   import crp_pkg::*;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cmp_valid = 1'b0, cmp_has_data = 1'b0, fc_valid = 1'b0, rx_valid = 1'b0;
   logic        slow = 1'b0;
   logic [3:0]  cmp_status = 4'h0, fc_code = 4'h0, rx_ftype = 4'h0, rx_trans = 4'h0;
   logic [3:0]  rx_status = 4'h0;
   logic [7:0]  cmp_tag = 8'h00, rx_tag = 8'h00;
   logic [63:0] cmp_data = 64'h0, rx_data = 64'h0;
   logic        cmp_ready, tx_valid, tx_ready, tx_has_data, tx_bad, done_valid, done_has_data;
   logic        done_retry, done_interv, rx_malformed, rx_impl_valid;
   logic [3:0]  tx_ftype, tx_trans, tx_status, done_status;
   logic [7:0]  tx_tag, done_tag;
   logic [63:0] tx_data, done_data;
   int          bad_count = 0;
   int          samples_checked = 0;

   crp_codec uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmp_valid(cmp_valid),
      .cmp_ready(cmp_ready), .cmp_status(cmp_status), .cmp_tag(cmp_tag),
      .cmp_has_data(cmp_has_data), .cmp_data(cmp_data), .fc_valid(fc_valid), .fc_code(fc_code),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ftype(tx_ftype), .tx_trans(tx_trans),
      .tx_status(tx_status), .tx_request_tag_echo(tx_tag), .tx_has_data(tx_has_data),
      .tx_data(tx_data), .tx_bad_status(tx_bad), .rx_valid(rx_valid), .rx_ftype(rx_ftype),
      .rx_trans(rx_trans), .rx_status(rx_status), .rx_request_tag_echo(rx_tag),
      .rx_data(rx_data), .done_valid(done_valid), .done_status(done_status),
      .done_request_tag_echo(done_tag), .done_has_data(done_has_data), .done_data(done_data),
      .done_retry(done_retry), .done_interv(done_interv), .rx_malformed(rx_malformed),
      .rx_impl_valid(rx_impl_valid));
   crp_sink sink (.clk_sys(clk_sys), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_ftype(tx_ftype), .tx_trans(tx_trans), .tx_status(tx_status), .tx_tag(tx_tag),
      .tx_has_data(tx_has_data), .tx_data(tx_data), .tx_bad(tx_bad));

   always #5 clk_sys = ~clk_sys;

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Bounded wait on one condition, evaluated each falling edge
   task automatic wait_for(input int which);
      int n;
      int c0;
      n = 0;
      c0 = sink.pkt_count;
      while ((which == 0 && cmp_ready !== 1'b1) || (which == 1 && tx_valid !== 1'b1)
             || (which == 2 && sink.pkt_count == c0)) begin
         @(negedge clk_sys);
         n++;
         if (n > 60) begin
            chk("wait", 64'h0, 64'h1);
            summarize();
         end
      end
   endtask

   task automatic send_cmp(input logic [3:0] st, input logic hd, input logic ok, input logic rsv);
      logic [63:0] d;
      d = 64'hfedc_ba98_7654_3210 ^ {60'h0, st};
      @(negedge clk_sys);
      cmp_valid = 1'b1;
      cmp_status = st;
      cmp_tag = 8'h40 + 8'(st);
      cmp_has_data = hd;
      cmp_data = d;
      wait_for(0);
      @(negedge clk_sys);
      cmp_valid = 1'b0;
      cmp_data = ~d;
      if (sink.pkt_count == 0 || tx_valid === 1'b1) wait_for(2);
      chk("ftype", 64'(FTYPE_RESPONSE), 64'(sink.got_ftype));
      chk("trans", (ok && hd) ? 64'h8 : 64'h0, 64'(sink.got_trans));
      chk("status", 64'(st), 64'(sink.got_status));
      chk("tag", 64'h40 + 64'(st), 64'(sink.got_tag));
      chk("has_data", 64'(ok && hd), 64'(sink.got_has));
      chk("data", (ok && hd) ? d : 64'h0, sink.got_data);
      chk("bad_status", 64'(rsv), 64'(sink.got_bad));
   endtask

   task automatic scen_status();
      logic ok;
      logic rsv;
      for (int s = 0; s < 16; s++) begin
         ok = (s <= 1) || (s == 4) || (s == 5) || (s >= 12);
         rsv = (s == 6) || (s >= 8 && s <= 11);
         slow <= s[0];
         send_cmp(4'(s), s != 12, ok, rsv);
         if (s == 3) send_cmp(4'(s), 1'b1, ok, rsv);
      end
   endtask

   task automatic scen_fc();
      @(negedge clk_sys);
      fc_valid = 1'b1;
      fc_code = 4'h9;
      wait_for(1);
      fc_valid = 1'b0;
      wait_for(2);
      chk("fc_ftype", 64'(FTYPE_IMPL), 64'(sink.got_ftype));
      chk("fc_trans", 64'h9, 64'(sink.got_trans));
   endtask

   task automatic rx_one(input logic [3:0] ft, tr, st, input logic [2:0] exp);
      @(negedge clk_sys);
      rx_valid = 1'b1;
      rx_ftype = ft;
      rx_trans = tr;
      rx_status = st;
      rx_tag = {st, ft};
      rx_data = {16{st}};
      @(negedge clk_sys);
      rx_valid = 1'b0;
      rx_trans = ~tr;
      rx_status = ~st;
      rx_tag = ~rx_tag;
      rx_data = ~rx_data;
      chk("done_valid", 64'(exp[2]), 64'(done_valid));
      chk("malformed", 64'(exp[1]), 64'(rx_malformed));
      chk("impl_valid", 64'(exp[0]), 64'(rx_impl_valid));
      if (exp[2]) begin
         chk("done_tag", 64'({st, ft}), 64'(done_tag));
         chk("done_status", 64'(st), 64'(done_status));
         chk("done_has", 64'(tr == 4'h8), 64'(done_has_data));
         chk("done_data", (tr == 4'h8) ? {16{st}} : 64'h0, done_data);
         chk("done_retry", 64'(st == 4'h3), 64'(done_retry));
         chk("done_interv", 64'(st == 4'h4), 64'(done_interv));
      end
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      scen_status();
      scen_fc();
      rx_one(4'hd, 4'h8, 4'h0, 3'b100);
      rx_one(4'hd, 4'h0, 4'h3, 3'b100);
      rx_one(4'hd, 4'h8, 4'h4, 3'b100);
      rx_one(4'hd, 4'h0, 4'h5, 3'b100);
      rx_one(4'hd, 4'h8, 4'hc, 3'b100);
      rx_one(4'hd, 4'h1, 4'h0, 3'b010);
      rx_one(4'hd, 4'h0, 4'h6, 3'b010);
      rx_one(4'hd, 4'h0, 4'h9, 3'b010);
      rx_one(4'hd, 4'h8, 4'h7, 3'b010);
      rx_one(4'hf, 4'h2, 4'h0, 3'b001);
      rx_one(4'hc, 4'h0, 4'h0, 3'b000);
      chk("pkt_count", 64'd18, 64'(sink.pkt_count));
      chk("rsvd_ftype", 64'h0, 64'(sink.saw_rsvd_ftype));
      summarize();
   end
endmodule
